// ===== hw/bc_correlator.sv
// Contract
// - Eight 32-tap stages, multi-bit data, 1-bit reference.
// - Length 256/128/64/32 taps per precision.
// - Split mode gives two independent half correlators.
// - One mask bit per tap excludes it.
// - Weight-and-sum applies bit weighting to score.
// - Programmed offset added to weighted score.
// - Programmable delay before the cascade adder.
// - Preload registers double-buffer mask and reference.
// - Samples captured every rising clock edge.
// - Cascade input added to delayed score.
// - Split: scores on cascade and aux, no cascading.
// - Single mode: reference out on aux bits.
// - Array score output formatted by configuration.
// - Cascade output enable, processing continues.
// - Aux output enable, processing continues.
// - Transfer enable low copies preload into array.
// - Reference byte latched on load strobe rise.
// - 1x256 window shifts reference on line 7.
// - 8x32 window loads stages in parallel.
// - Window change leaves stored reference intact.
// - Mask loaded like reference from control data.
// - Control byte goes where select address says.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module bc_correlator
   import bc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   bc_link_if.dev link,
   input wire logic [7:0] sample_in,
   input wire logic [SCORE_W-1:0] cascade_in,
   output logic [7:0] array_score_out,
   output logic [SCORE_W-1:0] cascade_out,
   output logic cascade_oe,
   output logic [SPLIT_W-1:0] auxiliary_out,
   output logic aux_oe
);

   // All state of the correlator; every field resets to zero.
   typedef struct packed {
      logic [NROW-1:0][NTAP-1:0] data;
      logic [NROW-1:0][NTAP-1:0] ref_pre;
      logic [NROW-1:0][NTAP-1:0] ref_act;
      logic [NROW-1:0][NTAP-1:0] mask_pre;
      logic [NROW-1:0][NTAP-1:0] mask_act;
      logic rl_act;
      logic cl_act;
      logic [1:0] prec;
      logic split;
      logic weight_off;
      logic [7:0] offset;
      logic [DLY_W-1:0] delay;
      logic [SCORE_W-1:0] raw_a;
      logic [SPLIT_W-1:0] raw_b;
      logic [SCORE_W-1:0] adj;
      logic [DLY_DEPTH-1:0][SCORE_W-1:0] line;
      logic [SCORE_W-1:0] cas_out;
      logic cas_oe;
      logic [SPLIT_W-1:0] aux;
      logic aux_oe;
      logic [7:0] score;
   } bc_dev_s;

   bc_dev_s s_q;
   bc_dev_s s_d;

   // Next-state logic for the whole correlator.
   always_comb begin
      logic [1:0] pe;
      int rpl;
      int rl;
      int gl;
      int wl;
      int rp;
      logic bit_s;
      logic bit_r;
      logic bit_m;
      logic rref;
      logic cwr;
      logic mwr;
      logic [5:0] cnt;
      logic [SCORE_W-1:0] term;
      logic [SCORE_W-1:0] acc_a;
      logic [SCORE_W-1:0] acc_b;
      logic [SCORE_W-1:0] dly;
      pe = '0;
      rpl = 0;
      rl = 0;
      gl = 0;
      wl = 0;
      rp = 0;
      bit_s = 1'b0;
      bit_r = 1'b0;
      bit_m = 1'b0;
      cnt = '0;
      term = '0;
      acc_a = '0;
      acc_b = '0;
      dly = '0;
      rref = 1'b0;
      cwr = 1'b0;
      mwr = 1'b0;
      s_d = s_q;

      // A load strobe counts at its rising edge: low last cycle, high now.
      rref = s_q.rl_act & link.reference_load_n;
      cwr = s_q.cl_act & link.control_load_n;
      mwr = cwr && (link.control_select == SEL_MASK);
      s_d.rl_act = ~link.reference_load_n;
      s_d.cl_act = ~link.control_load_n;

      // Split halves cannot hold 8-bit data, so that case falls back to 4 bits.
      pe = (s_q.split && (s_q.prec == PREC_8)) ? PREC_4 : s_q.prec;
      rpl = s_q.split ? (HALF_ROWS >> pe) : (NROW >> pe);

      // Rows chain into lanes; each lane is one sample bit of the window.
      for (int r = 0; r < NROW; r++) begin
         rl = s_q.split ? (r % HALF_ROWS) : r;
         gl = r / rpl;
         wl = rl / rpl;
         rp = (r == 0) ? 0 : r - 1;
         bit_s = sample_in[gl];
         bit_r = link.reference_in[REF_MSB - gl];
         bit_m = link.control_data_in[REF_MSB - gl];
         if ((rl % rpl) != 0) begin
            // Inside a lane the row continues from the previous row's end.
            bit_s = s_q.data[rp][NTAP-1];
            bit_r = s_q.ref_pre[rp][NTAP-1];
            bit_m = s_q.mask_pre[rp][NTAP-1];
         end
         s_d.data[r] = {s_q.data[r][NTAP-2:0], bit_s};
         if (rref) begin
            s_d.ref_pre[r] = {s_q.ref_pre[r][NTAP-2:0], bit_r};
         end
         if (mwr) begin
            s_d.mask_pre[r] = {s_q.mask_pre[r][NTAP-2:0], bit_m};
         end

         // Count agreeing taps that are not masked.
         cnt = '0;
         for (int t = 0; t < NTAP; t++) begin
            // The match bit is built at one bit wide, so the inversion cannot spread upward.
            cnt = cnt + {5'h0, ~(s_q.data[r][t] ^ s_q.ref_act[r][t]) & ~s_q.mask_act[r][t]};
         end

         // Higher sample bits weigh by their binary position unless turned off.
         term = s_q.weight_off ? SCORE_W'(cnt) : (SCORE_W'(cnt) << wl);
         if (s_q.split && (r >= HALF_ROWS)) begin
            acc_b = SCORE_W'(acc_b + term);
         end else begin
            acc_a = SCORE_W'(acc_a + term);
         end
      end

      // Control byte destinations; unused selects are ignored.
      if (cwr) begin
         case (link.control_select)
            SEL_CFG: begin
               // Reference storage is left alone on a window change.
               s_d.prec = link.control_data_in[CFG_PREC_MSB:CFG_PREC_LSB];
               s_d.split = link.control_data_in[CFG_SPLIT];
               s_d.weight_off = link.control_data_in[CFG_WEIGHT_OFF];
            end
            SEL_OFFSET: begin
               s_d.offset = link.control_data_in;
            end
            SEL_DELAY: begin
               s_d.delay = link.control_data_in[DLY_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // The active array only changes here, so loading never disturbs a running correlation.
      if (!link.preload_transfer_n) begin
         s_d.ref_act = s_q.ref_pre;
         s_d.mask_act = s_q.mask_pre;
      end

      // Score pipeline: raw, offset, delay line, cascade sum.
      s_d.raw_a = acc_a;
      s_d.raw_b = acc_b[SPLIT_W-1:0];
      if (s_q.split) begin
         s_d.adj = SCORE_W'(SCORE_W'(s_q.raw_a[SPLIT_W-1:0]) + SCORE_W'(s_q.offset));
      end else begin
         s_d.adj = SCORE_W'(s_q.raw_a + SCORE_W'(s_q.offset));
      end
      s_d.line = {s_q.line[DLY_DEPTH-2:0], s_q.adj};
      dly = (s_q.delay == '0) ? s_q.adj : s_q.line[s_q.delay - DLY_STEP];

      // In split mode the cascade input is not used at all.
      if (s_q.split) begin
         s_d.cas_out = SCORE_W'(dly[SPLIT_W-1:0]);
         s_d.aux = s_q.raw_b;
      end else begin
         s_d.cas_out = SCORE_W'(dly + cascade_in);
         s_d.aux = '0;
         for (int k = 0; k < NROW; k++) begin
            s_d.aux[k] = s_q.ref_act[REF_MSB - k][NTAP-1];
         end
      end

      // The byte output saturates rather than wrapping on wide windows.
      s_d.score = (s_q.raw_a > SCORE_W'(SAT_MAX)) ? SAT_MAX : s_q.raw_a[7:0];

      // Enables only gate the pins; the pipeline keeps running.
      s_d.cas_oe = ~link.cascade_out_enable_n;
      s_d.aux_oe = ~link.aux_out_enable_n;
   end

   // State register.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register.
   assign array_score_out = s_q.score;
   assign cascade_out = s_q.cas_out;
   assign cascade_oe = s_q.cas_oe;
   assign auxiliary_out = s_q.aux;
   assign aux_oe = s_q.aux_oe;

endmodule
`default_nettype wire

// ===== pkg/bc_pkg.sv
`default_nettype none
package bc_pkg;
   // Array geometry.
   localparam int NROW = 8;
   localparam int NTAP = 32;
   localparam int HALF_ROWS = 4;
   localparam int REF_MSB = 7;
   localparam int SCORE_W = 13;
   localparam int SPLIT_W = 9;
   localparam int DLY_DEPTH = 16;
   localparam int DLY_W = 4;
   localparam logic [DLY_W-1:0] DLY_STEP = 4'h1;
   localparam logic [7:0] SAT_MAX = 8'hFF;

   // Precision codes: 1, 2, 4 or 8 bits per sample.
   localparam logic [1:0] PREC_1 = 2'h0;
   localparam logic [1:0] PREC_4 = 2'h2;
   localparam logic [1:0] PREC_8 = 2'h3;

   // Control select decode.
   localparam logic [2:0] SEL_MASK = 3'h0;
   localparam logic [2:0] SEL_CFG = 3'h1;
   localparam logic [2:0] SEL_OFFSET = 3'h2;
   localparam logic [2:0] SEL_DELAY = 3'h3;

   // Configuration byte fields.
   localparam int CFG_PREC_LSB = 0;
   localparam int CFG_PREC_MSB = 1;
   localparam int CFG_SPLIT = 2;
   localparam int CFG_WEIGHT_OFF = 3;

   // Controller register offsets on APB.
   localparam logic [31:0] A_CMD = 32'h0000_0000;
   localparam logic [31:0] A_STAT = 32'h0000_0004;
   localparam logic [31:0] A_XFER = 32'h0000_0008;
   localparam logic [31:0] A_OE = 32'h0000_000C;

   // Command, status, transfer and enable word fields.
   localparam int CMD_SEL_LSB = 0;
   localparam int CMD_SEL_MSB = 2;
   localparam int CMD_KIND = 8;
   localparam int CMD_DATA_LSB = 16;
   localparam int CMD_DATA_MSB = 23;
   localparam int STAT_BUSY = 0;
   localparam int XFER_GO = 0;
   localparam int OE_CAS = 0;
   localparam int OE_AUX = 1;
endpackage
`default_nettype wire

// ===== pkg/bc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// Load, transfer and enable lines from the controller to the correlator.
interface bc_link_if;
   logic [7:0] reference_in;
   logic reference_load_n;
   logic [7:0] control_data_in;
   logic control_load_n;
   logic [2:0] control_select;
   logic preload_transfer_n;
   logic cascade_out_enable_n;
   logic aux_out_enable_n;

   modport dev (
      input reference_in,
      input reference_load_n,
      input control_data_in,
      input control_load_n,
      input control_select,
      input preload_transfer_n,
      input cascade_out_enable_n,
      input aux_out_enable_n
   );

   modport ctl (
      output reference_in,
      output reference_load_n,
      output control_data_in,
      output control_load_n,
      output control_select,
      output preload_transfer_n,
      output cascade_out_enable_n,
      output aux_out_enable_n
   );
endinterface
`default_nettype wire

// ===== hw/bc_controller.sv
`timescale 1ns/10ps
`default_nettype none
module bc_controller
   import bc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   bc_link_if.ctl link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW = 2'b01,
      ST_HIGH = 2'b10
   } bc_st_e;

   // All state of the controller.
   typedef struct packed {
      bc_st_e st;
      logic kind;
      logic [2:0] sel;
      logic [7:0] data;
      logic rl_n;
      logic cl_n;
      logic xfer_n;
      logic [1:0] oe_n;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } bc_ctl_s;

   bc_ctl_s s_q;
   bc_ctl_s s_d;

   // Bus decode, load sequencer and strobe generation.
   always_comb begin
      logic acc;
      logic wr;
      acc = psel & penable & ~s_q.pready;
      wr = psel & penable & s_q.pready & pwrite;
      s_d = s_q;
      s_d.xfer_n = 1'b1;
      s_d.pready = acc;
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;

      // Read data is registered together with pready, in the same cycle.
      if (acc) begin
         case (paddr)
            A_CMD: begin
               s_d.prdata[CMD_SEL_MSB:CMD_SEL_LSB] = s_q.sel;
               s_d.prdata[CMD_KIND] = s_q.kind;
               s_d.prdata[CMD_DATA_MSB:CMD_DATA_LSB] = s_q.data;
            end
            A_STAT: s_d.prdata[STAT_BUSY] = (s_q.st != ST_IDLE);
            A_XFER: s_d.prdata = '0;
            A_OE: s_d.prdata[OE_AUX:OE_CAS] = ~s_q.oe_n;
            default: s_d.pslverr = 1'b1;
         endcase
      end

      // Sequencer: one cycle strobe low, one cycle high with data held.
      case (s_q.st)
         ST_IDLE: s_d.st = ST_IDLE;
         ST_LOW: s_d.st = ST_HIGH;
         ST_HIGH: s_d.st = ST_IDLE;
         default: s_d.st = ST_IDLE;
      endcase

      // A command while busy is dropped so held data never changes under a strobe.
      if (wr) begin
         case (paddr)
            A_CMD: begin
               if (s_q.st == ST_IDLE) begin
                  s_d.sel = pwdata[CMD_SEL_MSB:CMD_SEL_LSB];
                  s_d.kind = pwdata[CMD_KIND];
                  s_d.data = pwdata[CMD_DATA_MSB:CMD_DATA_LSB];
                  s_d.st = ST_LOW;
               end
            end
            A_XFER: s_d.xfer_n = ~pwdata[XFER_GO];
            A_OE: s_d.oe_n = ~pwdata[OE_AUX:OE_CAS];
            default: begin
            end
         endcase
      end

      s_d.rl_n = ~((s_d.st == ST_LOW) & s_d.kind);
      s_d.cl_n = ~((s_d.st == ST_LOW) & ~s_d.kind);
   end

   // State register; strobes and enables reset inactive high.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.rl_n <= 1'b1;
         s_q.cl_n <= 1'b1;
         s_q.xfer_n <= 1'b1;
         s_q.oe_n <= 2'h3;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.reference_in = s_q.data;
   assign link.control_data_in = s_q.data;
   assign link.control_select = s_q.sel;
   assign link.reference_load_n = s_q.rl_n;
   assign link.control_load_n = s_q.cl_n;
   assign link.preload_transfer_n = s_q.xfer_n;
   assign link.cascade_out_enable_n = s_q.oe_n[OE_CAS];
   assign link.aux_out_enable_n = s_q.oe_n[OE_AUX];
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;

endmodule
`default_nettype wire

// ===== verification/bc_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the load lines that the controller drives into the correlator.
module bc_link_asserts (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reference_in,
   input wire logic reference_load_n,
   input wire logic [7:0] control_data_in,
   input wire logic control_load_n,
   input wire logic [2:0] control_select,
   input wire logic preload_transfer_n,
   input wire logic cascade_out_enable_n,
   input wire logic aux_out_enable_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // A strobe falls, then must stay high long enough for the busy gap.
   sequence s_ref_go;
      $fell(reference_load_n);
   endsequence
   sequence s_ctl_go;
      $fell(control_load_n);
   endsequence
   sequence s_gap(logic s);
      s ##1 s;
   endsequence
   // Named form of the gap, kept apart so the reference check reads plainly.
   sequence s_ref_gap_ok;
      s_gap(reference_load_n);
   endsequence

   a_ref_pulse_gap: assert property (s_ref_go |=> s_ref_gap_ok)
      else $error("reference strobe not a single low cycle");
   a_ctl_pulse_gap: assert property (s_ctl_go |=> s_gap(control_load_n))
      else $error("control strobe not a single low cycle");
   a_xfer_one_cycle: assert property ($fell(preload_transfer_n) |=> preload_transfer_n)
      else $error("transfer enable low too long");
   a_ref_data_hold: assert property (!reference_load_n |=> $stable(reference_in))
      else $error("reference byte moved before the strobe rose");
   a_ctl_data_hold: assert property (!control_load_n |=>
      $stable(control_data_in) && $stable(control_select))
      else $error("control byte or select moved before the strobe rose");
   a_one_strobe: assert property (!reference_load_n |-> control_load_n)
      else $error("both load strobes low together");
   a_idle_strobes: assert property ($rose(rst_n) |->
      reference_load_n && control_load_n && preload_transfer_n)
      else $error("strobes not idle after reset");
   a_idle_enables: assert property ($rose(rst_n) |->
      cascade_out_enable_n && aux_out_enable_n)
      else $error("output enables active after reset");
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import bc_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] sample_in = 8'h00;
   logic [SCORE_W-1:0] cascade_in = 13'h0000;
   logic [7:0] array_score_out;
   logic [SCORE_W-1:0] cascade_out;
   logic cascade_oe;
   logic [SPLIT_W-1:0] auxiliary_out;
   logic aux_oe;
   int err_total = 0;
   int comparisons = 0;
   // The enables turn the score buses into three-state pins, as on a board.
   wire [SCORE_W-1:0] cas_pin = cascade_oe ? cascade_out : 'z;
   wire [SPLIT_W-1:0] aux_pin = aux_oe ? auxiliary_out : 'z;

   bc_link_if link_bus ();
   bc_controller bc_controller_inst (.core_clk, .rst_n, .link(link_bus.ctl), .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   bc_correlator bc_correlator_inst (.core_clk, .rst_n, .link(link_bus.dev), .sample_in,
      .cascade_in, .array_score_out, .cascade_out, .cascade_oe, .auxiliary_out, .aux_oe);
   bc_link_asserts bc_link_asserts_inst (.core_clk, .rst_n,
      .reference_in(link_bus.reference_in), .reference_load_n(link_bus.reference_load_n),
      .control_data_in(link_bus.control_data_in), .control_load_n(link_bus.control_load_n),
      .control_select(link_bus.control_select),
      .preload_transfer_n(link_bus.preload_transfer_n),
      .cascade_out_enable_n(link_bus.cascade_out_enable_n),
      .aux_out_enable_n(link_bus.aux_out_enable_n));

   // Free running 200 MHz clock.
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic print_verdict();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic hang();
      err_total++;
      $display("mismatch at %0t: wait ran out", $time);
      print_verdict();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         err_total++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
   endtask

   // One APB transfer; the request stands until pready is sampled high.
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   // A load command, then polling busy so the next one is never dropped.
   task automatic cmd(input logic kind, input logic [2:0] sel, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      int n;
      apb(1'b1, A_CMD, {8'h00, d, 7'h00, kind, 5'h00, sel}, r, e);
      n = 0;
      do begin
         apb(1'b0, A_STAT, 32'h0, r, e);
         n++;
      end while (r[STAT_BUSY] !== 1'b0 && n < 20);
      if (r[STAT_BUSY] !== 1'b0) hang();
   endtask

   task automatic xfer();
      logic [31:0] r;
      logic e;
      apb(1'b1, A_XFER, 32'h1, r, e);
   endtask

   // Long enough for the pipeline plus the largest delay used here.
   task automatic settle();
      repeat (24) @(posedge core_clk);
   endtask

   // Writes an offset and counts cycles until the cascade sum moves.
   task automatic lat(input logic [7:0] off, output int n);
      logic [31:0] r;
      logic e;
      logic [SCORE_W-1:0] old;
      old = cascade_out;
      apb(1'b1, A_CMD, {8'h00, off, 16'h0002}, r, e);
      n = 0;
      while (cascade_out === old && n < 60) begin
         @(posedge core_clk);
         n++;
      end
      if (cascade_out === old) hang();
   endtask

   task automatic t_reset();
      logic [31:0] r;
      logic e;
      apb(1'b0, A_OE, 32'h0, r, e);
      check(r, 32'h0);
      check(cas_pin, {19'h0, 13'bz});
      check(aux_pin, {23'h0, 9'bz});
      check(cascade_out, 32'h100);
      check(array_score_out, 32'hFF);
      check(auxiliary_out[7:0], 32'h0);
      apb(1'b0, 32'h0000_0020, 32'h0, r, e);
      check(e, 32'h1);
      check(r, 32'h0);
      $display("reset test done");
   endtask

   task automatic t_cascade();
      logic [31:0] r;
      logic e;
      cascade_in <= 13'h0123;
      settle();
      check(cascade_out, 32'h223);
      apb(1'b1, A_OE, 32'h3, r, e);
      apb(1'b0, A_OE, 32'h0, r, e);
      check(r, 32'h3);
      check(cas_pin, 32'h223);
      check(aux_pin, 32'h0);
      $display("cascade test done");
   endtask

   task automatic t_offset();
      int n0;
      int n1;
      logic [31:0] r;
      logic e;
      lat(8'h21, n0);
      settle();
      check(cascade_out, 32'h244);
      cmd(1'b0, 3'h3, 8'h05);
      settle();
      lat(8'h00, n1);
      settle();
      check(cascade_out, 32'h223);
      check(n1 - n0, 32'h5);
      cmd(1'b0, 3'h2, 8'h21);
      apb(1'b0, A_CMD, 32'h0, r, e);
      check(r, 32'h0021_0002);
      $display("offset and delay test done");
   endtask

   // Mask taps 0..2, then reference ones on taps 0..4 through line 7 only.
   task automatic t_mask();
      cascade_in <= 13'h0000;
      repeat (3) cmd(1'b0, 3'h0, 8'h80);
      settle();
      check(cascade_out, 32'h121);
      xfer();
      settle();
      check(cascade_out, 32'h11E);
      check(array_score_out, 32'hFD);
      cmd(1'b1, 3'h0, 8'h7F);
      repeat (5) cmd(1'b1, 3'h0, 8'hFF);
      settle();
      check(cascade_out, 32'h11E);
      xfer();
      settle();
      check(cascade_out, 32'h11C);
      check(array_score_out, 32'hFB);
      $display("mask and reference test done");
   endtask

   task automatic t_split();
      cascade_in <= 13'h0155;
      cmd(1'b0, 3'h1, 8'h04);
      settle();
      check(cascade_out, 32'h09C);
      check(aux_pin, 32'h080);
      $display("split test done");
   endtask

   // Eight rows of 32: weighting off and on, parallel load, lane select.
   task automatic t_wide();
      cascade_in <= 13'h0000;
      cmd(1'b0, 3'h1, 8'h0B);
      settle();
      check(cascade_out, 32'h11C);
      check(array_score_out, 32'hFB);
      cmd(1'b0, 3'h1, 8'h03);
      settle();
      check(cascade_out, 32'h1FFC);
      cmd(1'b0, 3'h1, 8'h0B);
      cmd(1'b1, 3'h0, 8'h01);
      xfer();
      settle();
      check(cascade_out, 32'h11A);
      sample_in <= 8'h80;
      settle();
      settle();
      check(cascade_out, 32'h0FC);
      $display("wide window test done");
   endtask

   // Reset, then each scenario in turn.
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      settle();
      t_reset();
      t_cascade();
      t_offset();
      t_mask();
      t_split();
      t_wide();
      print_verdict();
   end
endmodule
`default_nettype wire
